/* File: verilog/tws_slave_port.sv */
// Two-wire slave port: framing, addressing, pointer access, alert, Hs, timeout
`timescale 1ns/1ps
`default_nettype none
module tws_slave_port #(
   parameter int P_TIMEOUT_CYCLES = tws_pkg::TIMEOUT_CYCLES
) (
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic i_addr_sel_pin_hi,
   input wire logic i_addr_sel_pin_lo,
   input wire logic [15:0] i_rd_data,
   input wire tws_pkg::tws_alert_type i_alert,
   output logic o_sda_out,
   output logic o_sda_oe,
   output logic [7:0] o_pointer,
   output var tws_pkg::tws_wr_type o_wr,
   output logic o_gc_reset,
   output logic o_hs_mode,
   output logic o_alert_clear
);

   // ==========================================================
   // Pin synchronisers
   logic [3:0] sync;
   logic scl_s;
   logic sda_s;
   logic pin_hi_s;
   logic pin_lo_s;

   tws_sync2 #(.W(4)) u_sync (
      .i_core_clk(i_core_clk),
      .i_reset_n(i_reset_n),
      .i_async({i_scl, i_sda, i_addr_sel_pin_hi, i_addr_sel_pin_lo}),
      .o_sync(sync)
   );

   assign scl_s = sync[3];
   assign sda_s = sync[2];
   assign pin_hi_s = sync[1];
   assign pin_lo_s = sync[0];

   // ==========================================================
   // State
   tws_pkg::tws_state_type q;
   tws_pkg::tws_state_type d;

   logic scl_rise;
   logic scl_fall;
   logic start_ev;
   logic stop_ev;
   logic timeout_ev;
   logic byte_ev;
   logic [6:0] own_addr;
   logic ack;

   assign scl_rise = scl_s & ~q.scl_prev;
   assign scl_fall = ~scl_s & q.scl_prev;
   assign start_ev = scl_s & q.scl_prev & q.sda_prev & ~sda_s;
   assign stop_ev = scl_s & q.scl_prev & ~q.sda_prev & sda_s;
   assign timeout_ev = q.in_txn & ~scl_s
      & (q.to_cnt == tws_pkg::tws_tocnt_type'(P_TIMEOUT_CYCLES - 1));
   assign byte_ev = scl_fall & (q.fsm == tws_pkg::ST_RX)
      & (q.bit_cnt == tws_pkg::BITS_PER_BYTE);
   assign own_addr = {tws_pkg::ADDR_UPPER, q.addr_hi, q.addr_lo};

   always_comb begin
      d = q;
      ack = 1'b0;
      d.wr.stb = 1'b0;
      d.gc_reset = 1'b0;
      d.alert_clear = 1'b0;
      d.scl_prev = scl_s;
      d.sda_prev = sda_s;

      // ==========================================================
      // Address pin strapping, refined as the bus moves
      if (!q.in_txn && scl_s && sda_s) begin
         d.addr_hi = pin_hi_s;
         d.addr_lo = pin_lo_s ? tws_pkg::SEL_HIGH : tws_pkg::SEL_LOW;
      end
      if (start_ev && !pin_lo_s && q.addr_lo != tws_pkg::SEL_LOW) begin
         d.addr_lo = tws_pkg::SEL_SDA;
      end
      // A pin tied to SCL is the only candidate low while SCL is low
      if (scl_fall && q.first_byte && q.bit_cnt == 4'h0
            && q.addr_lo == tws_pkg::SEL_HIGH && !pin_lo_s) begin
         d.addr_lo = tws_pkg::SEL_SCL;
      end

      // ==========================================================
      // Bus timeout counter
      if (q.in_txn && !scl_s) begin
         d.to_cnt = q.to_cnt + 1'b1;
      end else begin
         d.to_cnt = '0;
      end

      if (timeout_ev) begin
         // Released and idle until the next start
         d.fsm = tws_pkg::ST_IDLE;
         d.in_txn = 1'b0;
         d.sda_oe = 1'b0;
         d.to_cnt = '0;
         d.msb_pend = 1'b0;
      end else if (stop_ev || start_ev) begin
         if (q.msb_pend) begin
            d.wr.stb = 1'b1;
            d.wr.be = tws_pkg::BE_MSB;
            d.wr.data = {q.msb_hold, 8'h00};
            d.msb_pend = 1'b0;
         end
         if (q.alert_won) begin
            d.alert_clear = 1'b1;
            d.alert_won = 1'b0;
         end
         d.sda_oe = 1'b0;
         d.txn = tws_pkg::TX_NONE;
         d.bit_cnt = 4'h0;
         if (stop_ev) begin
            d.fsm = tws_pkg::ST_IDLE;
            d.in_txn = 1'b0;
            d.hs_mode = 1'b0;
         end else begin
            d.fsm = tws_pkg::ST_RX;
            d.in_txn = 1'b1;
            d.first_byte = 1'b1;
            d.byte_idx = tws_pkg::BYTE_ADDR;
         end
      end else begin
         unique case (q.fsm)
            tws_pkg::ST_IDLE: begin
            end
            tws_pkg::ST_RX: begin
               if (scl_rise) begin
                  d.shift = {q.shift[6:0], sda_s};
                  d.bit_cnt = q.bit_cnt + 4'h1;
               end
               if (byte_ev) begin
                  d.first_byte = 1'b0;
                  unique case (q.byte_idx)
                     tws_pkg::BYTE_ADDR: begin
                        if (q.first_byte && q.shift[7:3] == tws_pkg::HS_PREFIX) begin
                           d.hs_mode = 1'b1;
                        end else if (q.shift[7:1] == own_addr) begin
                           ack = 1'b1;
                           d.txn = q.shift[0] ? tws_pkg::TX_READ : tws_pkg::TX_WRITE;
                        end else if (q.shift[7:1] == tws_pkg::GC_ADDR && !q.shift[0]) begin
                           ack = 1'b1;
                           d.txn = tws_pkg::TX_GCALL;
                        end else if (q.shift[7:1] == tws_pkg::ARA_ADDR && q.shift[0]
                              && i_alert.active && i_alert.latch_mode_sel) begin
                           ack = 1'b1;
                           d.txn = tws_pkg::TX_ALERT;
                        end
                     end
                     tws_pkg::BYTE_PTR: begin
                        if (q.txn == tws_pkg::TX_WRITE) begin
                           ack = 1'b1;
                           d.pointer = q.shift;
                        end else if (q.txn == tws_pkg::TX_GCALL) begin
                           ack = 1'b1;
                           if (q.shift == tws_pkg::GC_RESET_CMD) begin
                              d.gc_reset = 1'b1;
                              d.pointer = tws_pkg::POINTER_RESET;
                           end
                        end
                     end
                     tws_pkg::BYTE_MSB: begin
                        if (q.txn == tws_pkg::TX_WRITE) begin
                           ack = 1'b1;
                           d.msb_hold = q.shift;
                           d.msb_pend = 1'b1;
                        end
                     end
                     tws_pkg::BYTE_LSB: begin
                        if (q.txn == tws_pkg::TX_WRITE) begin
                           ack = 1'b1;
                           d.wr.stb = 1'b1;
                           d.wr.be = tws_pkg::BE_BOTH;
                           d.wr.data = {q.msb_hold, q.shift};
                           d.msb_pend = 1'b0;
                        end
                     end
                  endcase
                  // Anything not claimed above is left released
                  if (ack) begin
                     d.sda_oe = 1'b1;
                     d.fsm = tws_pkg::ST_RX_ACK;
                  end else begin
                     d.fsm = tws_pkg::ST_IDLE;
                  end
               end
            end
            tws_pkg::ST_RX_ACK: begin
               if (scl_fall) begin
                  d.bit_cnt = 4'h0;
                  d.sda_oe = 1'b0;
                  if (q.txn == tws_pkg::TX_READ) begin
                     d.fsm = tws_pkg::ST_TX;
                     d.byte_idx = tws_pkg::BYTE_MSB;
                     d.tx_word = i_rd_data;
                     d.sda_oe = ~i_rd_data[15];
                  end else if (q.txn == tws_pkg::TX_ALERT) begin
                     d.fsm = tws_pkg::ST_TX;
                     d.byte_idx = tws_pkg::BYTE_LSB;
                     d.tx_word = {own_addr, i_alert.above_high, 8'hff};
                     d.sda_oe = ~own_addr[6];
                  end else begin
                     d.fsm = tws_pkg::ST_RX;
                     d.byte_idx = (q.byte_idx == tws_pkg::BYTE_LSB)
                        ? tws_pkg::BYTE_MSB : q.byte_idx + 2'h1;
                  end
               end
            end
            tws_pkg::ST_TX: begin
               if (scl_rise) begin
                  d.bit_cnt = q.bit_cnt + 4'h1;
                  // A released one seen low means another responder won
                  if (q.txn == tws_pkg::TX_ALERT && q.tx_word[15] && !sda_s) begin
                     d.fsm = tws_pkg::ST_IDLE;
                  end
               end
               if (scl_fall) begin
                  d.tx_word = {q.tx_word[14:0], 1'b0};
                  d.sda_oe = ~q.tx_word[14];
                  if (q.bit_cnt == tws_pkg::BITS_PER_BYTE) begin
                     d.sda_oe = 1'b0;
                     d.fsm = tws_pkg::ST_TX_ACK;
                     if (q.txn == tws_pkg::TX_ALERT) begin
                        d.alert_won = 1'b1;
                     end
                  end
               end
            end
            tws_pkg::ST_TX_ACK: begin
               // Master nack ends the read; an alert reply is one byte only
               if (scl_rise && (sda_s || q.txn == tws_pkg::TX_ALERT)) begin
                  d.fsm = tws_pkg::ST_IDLE;
               end
               if (scl_fall) begin
                  d.bit_cnt = 4'h0;
                  d.fsm = tws_pkg::ST_TX;
                  if (q.byte_idx == tws_pkg::BYTE_MSB) begin
                     d.byte_idx = tws_pkg::BYTE_LSB;
                     d.sda_oe = ~q.tx_word[15];
                  end else begin
                     d.byte_idx = tws_pkg::BYTE_MSB;
                     d.tx_word = i_rd_data;
                     d.sda_oe = ~i_rd_data[15];
                  end
               end
            end
            default: begin
               d.fsm = tws_pkg::ST_IDLE;
               d.sda_oe = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         q <= tws_pkg::STATE_RESET;
      end else begin
         q <= d;
      end
   end

   // ==========================================================
   // Outputs: SDA is open drain, so only the enable moves
   assign o_sda_out = 1'b0;
   assign o_sda_oe = q.sda_oe;
   assign o_pointer = q.pointer;
   assign o_wr = q.wr;
   assign o_gc_reset = q.gc_reset;
   assign o_hs_mode = q.hs_mode;
   assign o_alert_clear = q.alert_clear;

   // ==========================================================
   // Checks
   AST_STOP_IDLE: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      stop_ev && !timeout_ev |=> q.fsm == tws_pkg::ST_IDLE && !q.in_txn && !q.sda_oe)
      else $error("stop did not return the port to idle");

   AST_OE_SCL_LOW: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      $changed(q.sda_oe) |-> !q.scl_prev)
      else $error("SDA drive changed while SCL high");

   AST_ACK_HELD: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      ((byte_ev && ack) || (q.fsm == tws_pkg::ST_RX_ACK && q.sda_oe && !scl_fall
      && !start_ev && !stop_ev)) && !timeout_ev |=> q.sda_oe)
      else $error("acknowledge not held through SCL high");

   AST_NO_FOREIGN_ACK: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      byte_ev && !start_ev && !stop_ev && !timeout_ev && q.byte_idx == tws_pkg::BYTE_ADDR
      && q.shift[7:1] != own_addr && q.shift[7:1] != tws_pkg::GC_ADDR
      && q.shift[7:1] != tws_pkg::ARA_ADDR |=> !q.sda_oe && q.fsm == tws_pkg::ST_IDLE)
      else $error("foreign address was acknowledged");

   AST_PTR_LOAD: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      byte_ev && !timeout_ev && q.byte_idx == tws_pkg::BYTE_PTR && q.txn == tws_pkg::TX_WRITE
      |=> q.pointer == $past(q.shift))
      else $error("pointer byte not loaded");

   AST_PTR_KEPT: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      q.txn == tws_pkg::TX_READ |=> $stable(q.pointer))
      else $error("pointer changed during a read");

   AST_WORD_WRITE: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      byte_ev && !timeout_ev && q.byte_idx == tws_pkg::BYTE_LSB && q.txn == tws_pkg::TX_WRITE
      |=> q.wr.stb && q.wr.be == tws_pkg::BE_BOTH && q.wr.data == {$past(q.msb_hold), $past(q.shift)}
      ##1 !q.wr.stb)
      else $error("word write strobe wrong");

   AST_MSB_ONLY: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      q.msb_pend && (start_ev || stop_ev) && !timeout_ev
      |=> q.wr.stb && q.wr.be == tws_pkg::BE_MSB && !q.msb_pend)
      else $error("cut write did not update the MSB");

   AST_GC_RESET: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      byte_ev && !timeout_ev && q.txn == tws_pkg::TX_GCALL && q.byte_idx == tws_pkg::BYTE_PTR
      && q.shift == tws_pkg::GC_RESET_CMD |=> o_gc_reset && q.pointer == tws_pkg::POINTER_RESET
      ##1 !o_gc_reset)
      else $error("general call reset not pulsed");

   AST_HS_HOLD: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      q.hs_mode && start_ev && !timeout_ev |=> q.hs_mode)
      else $error("high-speed mode lost at repeated start");

   AST_TIMEOUT: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      timeout_ev |=> !q.in_txn && !q.sda_oe && q.fsm == tws_pkg::ST_IDLE)
      else $error("timeout did not release the bus");

   AST_ALERT_LOST: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      q.fsm == tws_pkg::ST_TX && q.txn == tws_pkg::TX_ALERT && scl_rise && q.tx_word[15]
      && !sda_s && !start_ev && !stop_ev && !timeout_ev |=> !q.alert_won ##1 !o_alert_clear)
      else $error("lost arbitration still cleared the alert");

endmodule
`default_nettype wire

/* File: shared/tws_pkg.sv */
// Constants and types shared by the two-wire slave port
// Overview of operation
// - Address 1000, pin selects bit2, pin bits1:0
// - SDA fall/rise with SCL high: start/stop
// - Acknowledge matching address on ninth clock
// - SDA changes only while SCL low
// - Acknowledge held low through whole SCL high
// - First write byte loads register pointer
// - Reads use pointer, pointer kept until rewritten
// - Words travel MSB byte first, LSB second
// - Receive: ack address, pointer, two data bytes
// - Write cut after one byte updates MSB only
// - Transmit: send pointed register, two bytes
// - Alert response only in latching alert mode
// - Alert response: ack, return address plus cause
// - Arbitrate alert address; winner clears alert
// - Ack general call; command 06 resets registers
// - Hs master code: no ack, enter high speed
// - Hs kept over repeated start, left at stop
// - SCL low 30 ms mid-frame resets interface
// - Bits of every byte go MSB first
package tws_pkg;

   // ==========================================================
   // Addresses and codes
   localparam logic [3:0] ADDR_UPPER = 4'h8;
   localparam logic [6:0] GC_ADDR = 7'h00;
   localparam logic [7:0] GC_RESET_CMD = 8'h06;
   localparam logic [6:0] ARA_ADDR = 7'h0c;
   localparam logic [4:0] HS_PREFIX = 5'h01;
   localparam logic [7:0] POINTER_RESET = 8'h00;
   localparam logic [1:0] SEL_LOW = 2'h0;
   localparam logic [1:0] SEL_HIGH = 2'h1;
   localparam logic [1:0] SEL_SDA = 2'h2;
   localparam logic [1:0] SEL_SCL = 2'h3;

   // ==========================================================
   // Byte sequencing
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [1:0] BYTE_ADDR = 2'h0;
   localparam logic [1:0] BYTE_PTR = 2'h1;
   localparam logic [1:0] BYTE_MSB = 2'h2;
   localparam logic [1:0] BYTE_LSB = 2'h3;
   localparam logic [1:0] BE_MSB = 2'h2;
   localparam logic [1:0] BE_BOTH = 2'h3;

   // ==========================================================
   // Timing
   localparam int CLK_FREQ_KHZ = 200000;
   localparam int TIMEOUT_MS = 30;
   localparam int TIMEOUT_CYCLES = CLK_FREQ_KHZ * TIMEOUT_MS;
   localparam int TO_CNT_W = 23;
   typedef logic [TO_CNT_W-1:0] tws_tocnt_type;

   // ==========================================================
   // Types
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_RX = 3'b001,
      ST_RX_ACK = 3'b010,
      ST_TX = 3'b011,
      ST_TX_ACK = 3'b100
   } tws_fsm_type;

   typedef enum logic [2:0] {
      TX_NONE = 3'b000,
      TX_WRITE = 3'b001,
      TX_READ = 3'b010,
      TX_GCALL = 3'b011,
      TX_ALERT = 3'b100
   } tws_txn_type;

   typedef struct packed {
      logic stb;
      logic [1:0] be;
      logic [15:0] data;
   } tws_wr_type;

   typedef struct packed {
      logic active;
      logic latch_mode_sel;
      logic above_high;
   } tws_alert_type;

   typedef struct packed {
      tws_fsm_type fsm;
      tws_txn_type txn;
      logic scl_prev;
      logic sda_prev;
      logic [3:0] bit_cnt;
      logic [7:0] shift;
      logic [1:0] byte_idx;
      logic first_byte;
      logic in_txn;
      logic [7:0] pointer;
      logic [7:0] msb_hold;
      logic msb_pend;
      tws_wr_type wr;
      logic gc_reset;
      logic hs_mode;
      logic alert_won;
      logic alert_clear;
      logic sda_oe;
      logic [15:0] tx_word;
      logic [1:0] addr_lo;
      logic addr_hi;
      tws_tocnt_type to_cnt;
   } tws_state_type;

   localparam tws_state_type STATE_RESET = '{
      fsm: ST_IDLE, txn: TX_NONE, scl_prev: 1'b1, sda_prev: 1'b1,
      bit_cnt: 4'h0, shift: 8'h00, byte_idx: BYTE_ADDR, first_byte: 1'b0,
      in_txn: 1'b0, pointer: POINTER_RESET, msb_hold: 8'h00, msb_pend: 1'b0,
      wr: '{stb: 1'b0, be: 2'h0, data: 16'h0000}, gc_reset: 1'b0,
      hs_mode: 1'b0, alert_won: 1'b0, alert_clear: 1'b0, sda_oe: 1'b0,
      tx_word: 16'h0000, addr_lo: SEL_LOW, addr_hi: 1'b0, to_cnt: '0};

endpackage

/* File: verilog/tws_sync2.sv */
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none
module tws_sync2 #(
   parameter int W = 1
) (
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);
   // Stage 0 is read only by stage 1
   logic [1:0][W-1:0] st_q;
   logic [1:0][W-1:0] st_d;

   always_comb begin
      st_d[0] = i_async;
      st_d[1] = st_q[0];
   end

   // Idle bus lines are high, so reset to ones
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         st_q <= '1;
      end else begin
         st_q <= st_d;
      end
   end

   assign o_sync = st_q[1];
endmodule
`default_nettype wire

/* File: bench/tws_master_model.sv */
// Bus master model driving SCL and pulling SDA low on the two-wire link
`timescale 1ns/1ps
`default_nettype none
module tws_master_model (
   input wire logic i_core_clk,
   input wire logic i_sda,
   output logic o_scl,
   output logic o_sda_low
);
   // ==========================================================
   // Bit timing
   // 8 core cycles a phase gives an 80 ns SCL period, still 4x the sync latency
   localparam int HALF = 8;
   initial begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end
   task automatic waitc(input int n);
      repeat (n) @(posedge i_core_clk);
   endtask
   // Also serves as repeated start: SDA released while SCL low first
   task automatic start_cond();
      o_sda_low <= 1'b0;
      waitc(HALF / 2);
      o_scl <= 1'b1;
      waitc(HALF);
      o_sda_low <= 1'b1;
      waitc(HALF);
      o_scl <= 1'b0;
      waitc(HALF / 2);
   endtask
   task automatic stop_cond();
      o_sda_low <= 1'b1;
      waitc(HALF / 2);
      o_scl <= 1'b1;
      waitc(HALF);
      o_sda_low <= 1'b0;
      waitc(HALF);
   endtask
   // SCL runs at 12.5 MHz, far above the timeout floor
   task automatic xfer_bit(input logic b, output logic r);
      o_sda_low <= ~b;
      waitc(HALF / 2);
      o_scl <= 1'b1;
      waitc(HALF);
      r = i_sda;
      o_scl <= 1'b0;
      waitc(HALF / 2);
   endtask
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         xfer_bit(d[i], r);
      end
      xfer_bit(1'b1, r);
      ack = ~r;
   endtask
   task automatic rd_byte(input logic nack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         xfer_bit(1'b1, d[i]);
      end
      xfer_bit(nack, r);
   endtask
endmodule
`default_nettype wire

/* File: bench/tb_tws_slave_port.sv */
// Self-checking testbench of the two-wire slave port
`timescale 1ns/1ps
`default_nettype none
module tb_tws_slave_port;
   logic core_clk, reset_n, scl, m_sda_low, sda, pin_hi, pin_lo;
   logic sda_out, sda_oe, gc_reset, hs_mode, alert_clear;
   logic [1:0] pin_sel;
   logic [6:0] own;
   logic [7:0] pointer;
   logic [15:0] rd_data;
   tws_pkg::tws_alert_type alert;
   tws_pkg::tws_wr_type wr, wr_last;
   int fail_count, checks_done, gc_cnt, clr_cnt, wr_cnt;

   // ==========================================================
   // Wires and device under test
   assign sda = ~(m_sda_low | (sda_oe & ~sda_out));
   assign pin_lo = pin_sel[1] ? (pin_sel[0] ? scl : sda) : pin_sel[0];
   assign own = {tws_pkg::ADDR_UPPER, pin_hi, pin_sel};
   tws_master_model master (.i_core_clk(core_clk), .i_sda(sda), .o_scl(scl),
      .o_sda_low(m_sda_low));
   tws_slave_port #(.P_TIMEOUT_CYCLES(2000)) dut (.i_core_clk(core_clk),
      .i_reset_n(reset_n), .i_scl(scl), .i_sda(sda), .i_addr_sel_pin_hi(pin_hi),
      .i_addr_sel_pin_lo(pin_lo), .i_rd_data(rd_data), .i_alert(alert),
      .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_pointer(pointer), .o_wr(wr),
      .o_gc_reset(gc_reset), .o_hs_mode(hs_mode), .o_alert_clear(alert_clear));
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   // Register file stand-in: value tracks the pointer so reads reveal it
   always @(posedge core_clk) begin
      rd_data <= {8'hc3, pointer};
      if (wr.stb) wr_last <= wr;
      wr_cnt <= wr_cnt + int'(wr.stb);
      gc_cnt <= gc_cnt + int'(gc_reset);
      clr_cnt <= clr_cnt + int'(alert_clear);
   end

   // ==========================================================
   // Checking and closing
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic frame(input logic [7:0] b, output logic a);
      master.start_cond();
      master.wr_byte(b, a);
   endtask

   // ==========================================================
   // Scenarios
   task automatic sc_addr();
      logic a;
      for (int k = 0; k < 8; k++) begin
         pin_hi <= k[2];
         pin_sel <= k[1:0];
         master.waitc(8);
         frame({own, 1'b0}, a);
         chk(16'(a), 16'h0001);
         frame({own ^ 7'h04, 1'b0}, a);
         chk(16'(a), 16'h0000);
         master.stop_cond();
      end
   endtask
   task automatic sc_write();
      logic a0, a1, a2, a3;
      int n;
      n = wr_cnt;
      frame({own, 1'b0}, a0);
      master.wr_byte(8'h5a, a1);
      master.wr_byte(8'h12, a2);
      master.wr_byte(8'h34, a3);
      master.stop_cond();
      chk({12'h000, a0, a1, a2, a3}, 16'h000f);
      chk(16'(pointer), 16'h005a);
      chk(wr_last.data, 16'h1234);
      chk(16'(wr_last.be), 16'(tws_pkg::BE_BOTH));
      chk(16'(wr_cnt - n), 16'h0001);
      frame({own, 1'b0}, a0);
      master.wr_byte(8'h07, a1);
      master.wr_byte(8'hab, a2);
      master.stop_cond();
      chk(wr_last.data, 16'hab00);
      chk(16'(wr_last.be), 16'(tws_pkg::BE_MSB));
   endtask
   task automatic sc_read();
      logic a;
      logic [7:0] hi, lo;
      frame({own, 1'b0}, a);
      master.wr_byte(8'h33, a);
      for (int k = 0; k < 2; k++) begin
         frame({own, 1'b1}, a);
         master.rd_byte(1'b0, hi);
         master.rd_byte(1'b1, lo);
         chk({hi, lo}, 16'hc333);
      end
      master.stop_cond();
   endtask
   task automatic sc_gcall();
      logic a0, a1;
      int n;
      n = gc_cnt;
      frame(8'h00, a0);
      master.wr_byte(tws_pkg::GC_RESET_CMD, a1);
      master.stop_cond();
      chk({14'h0000, a0, a1}, 16'h0003);
      chk(16'(gc_cnt - n), 16'h0001);
      chk(16'(pointer), 16'h0000);
      frame(8'h01, a0);
      master.stop_cond();
      chk(16'(a0), 16'h0000);
   endtask
   task automatic sc_hs();
      logic a;
      frame(8'h0d, a);
      chk({15'h0000, a}, 16'h0000);
      chk(16'(hs_mode), 16'h0001);
      frame({own, 1'b0}, a);
      chk({hs_mode, 14'h0000, a}, 16'h8001);
      master.stop_cond();
      chk(16'(hs_mode), 16'h0000);
   endtask
   task automatic sc_alert();
      logic a;
      logic [7:0] d;
      int n;
      alert <= '{1'b1, 1'b1, 1'b1};
      n = clr_cnt;
      frame(8'h19, a);
      master.wr_byte(8'h00, a);
      master.stop_cond();
      chk(16'(clr_cnt - n), 16'h0000);
      frame(8'h19, a);
      master.rd_byte(1'b1, d);
      master.stop_cond();
      chk({7'h00, a, d}, {8'h01, own, 1'b1});
      chk(16'(clr_cnt - n), 16'h0001);
      alert <= '{1'b1, 1'b1, 1'b0};
      frame(8'h19, a);
      master.rd_byte(1'b1, d);
      master.stop_cond();
      chk({7'h00, a, d}, {8'h01, own, 1'b0});
      alert <= '{1'b1, 1'b0, 1'b0};
      frame(8'h19, a);
      master.stop_cond();
      chk(16'(a), 16'h0000);
      alert <= '0;
   endtask
   task automatic sc_timeout();
      logic [7:0] b;
      logic r;
      b = {own, 1'b0};
      master.start_cond();
      for (int i = 7; i >= 0; i--) begin
         master.xfer_bit(b[i], r);
      end
      master.waitc(40);
      chk(16'(sda_oe), 16'h0001);
      master.waitc(2500);
      chk(16'(sda_oe), 16'h0000);
      master.stop_cond();
      frame(b, r);
      master.stop_cond();
      chk(16'(r), 16'h0001);
   endtask

   // ==========================================================
   // Main sequence and watchdog
   initial begin
      reset_n = 1'b0;
      pin_hi = 1'b1;
      pin_sel = 2'h1;
      alert = '0;
      rd_data = 16'h0000;
      wr_last = '0;
      {fail_count, checks_done, gc_cnt, clr_cnt, wr_cnt} = '0;
      repeat (16) @(posedge core_clk);
      reset_n <= 1'b1;
      master.waitc(8);
      chk({sda_oe, hs_mode, 6'h00, pointer}, 16'h0000);
      sc_addr();
      sc_write();
      sc_read();
      sc_gcall();
      sc_hs();
      sc_alert();
      sc_timeout();
      end_sim();
   end
   initial begin
      repeat (40000) @(posedge core_clk);
      fail_count++;
      end_sim();
   end
endmodule
`default_nettype wire
